//--- common/wdt_pkg.sv
// Package for the eight-bit watchdog: register map, field layout, resets,
// prescaler and reset-pulse counts, bus carrier types.
// Assumes an AHB-Lite slave with 32-bit data, one register per word.
package wdt_pkg;

	// Register indices (printed offsets are not all multiples of four, so
	// the printed offset is the index and the byte address is four times it)
	localparam logic [15:0] IDX_CTRL_STATUS  = 16'hFFB2;
	localparam logic [15:0] IDX_COUNTER      = 16'hFFB3;
	localparam logic [15:0] IDX_PORT_SEL_3   = 16'hFFCA;
	localparam logic [15:0] IDX_CLOCK_STOP_2 = 16'hFFFB;
	// Block-local mode register (power mode of the chip, set by software)
	localparam logic [15:0] IDX_POWER_MODE   = 16'hFFF0;
	localparam int          ADDR_W           = 18;

	// Control/status field positions
	localparam int BIT_CNT_WR_INH  = 7;
	localparam int BIT_CNT_WR_EN   = 6;
	localparam int BIT_UNLOCK_INH  = 5;
	localparam int BIT_UNLOCK      = 4;
	localparam int BIT_ENABLE_INH  = 3;
	localparam int BIT_ENABLE      = 2;
	localparam int BIT_FLAG_INH    = 1;
	localparam int BIT_FLAG        = 0;
	// Clock-source select in port select 3, standby bit in clock stop 2
	localparam int BIT_CLK_SEL     = 5;
	localparam int BIT_STANDBY_N   = 2;

	// Reset values
	localparam logic [7:0] RST_CTRL_STATUS  = 8'hAA;
	localparam logic [7:0] RST_COUNTER      = 8'h00;
	localparam logic [7:0] RST_PORT_SEL_3   = 8'h00;
	localparam logic [7:0] RST_CLOCK_STOP_2 = 8'hFF;
	localparam logic [7:0] INHIBIT_MASK     = 8'hAA;

	// Prescaler ratios and reset pulse length
	localparam int SYS_DIVIDE     = 8192;
	localparam int SUB_DIVIDE     = 32;
	localparam int RESET_OSC_CYC  = 512;

	// Chip power modes
	typedef enum logic [2:0]
	{
		WDT_ACTIVE    = 3'b000,
		WDT_SLEEP     = 3'b001,
		WDT_WATCH     = 3'b010,
		WDT_SUBACTIVE = 3'b011,
		WDT_SUBSLEEP  = 3'b100,
		WDT_STANDBY   = 3'b101
	} wdt_mode_t;

	// Bus address phase as captured by the slave
	typedef struct packed
	{
		logic              write;
		logic [ADDR_W-1:0] addr;
	} wdt_req_t;

endpackage : wdt_pkg

//--- hdl/wdt_core.sv
// Eight-bit watchdog with AHB-Lite register access.
// Assumes subclock and oscillator clock arrive as level inputs from other
// domains, and the external reset pin is a separate active-low input.
//
// Design decision made here: the AHB-Lite slave port.

module wdt_core
#(
	parameter int SYS_DIV = wdt_pkg::SYS_DIVIDE,
	parameter int SUB_DIV = wdt_pkg::SUB_DIVIDE,
	parameter int RST_LEN = wdt_pkg::RESET_OSC_CYC
)
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        external_reset_pin_n_i,
	// Slow clocks sampled as levels
	input  wire logic        sub_clk_i,
	input  wire logic        osc_clk_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Chip reset
	output logic             internal_reset_o
);

	localparam int PW = $clog2(SYS_DIV);
	localparam int RW = $clog2(RST_LEN) + 1;

	// Synchronisers for pin and foreign-clock levels
	logic [1:0] pin_sync;
	logic [1:0] sub_sync;
	logic [1:0] osc_sync;
	logic       sub_prev;
	logic       osc_prev;
	logic       sub_rise;
	logic       osc_rise;

	// Registers
	logic       counter_write_enable;
	logic       control_write_unlock;
	logic       watchdog_enable;
	logic       overflow_reset_flag;
	logic [7:0] watchdog_counter;
	logic [7:0] port_function_select_3;
	logic [7:0] module_clock_stop_reg;
	wdt_pkg::wdt_mode_t power_mode;

	// Bus
	wdt_pkg::wdt_req_t req;
	logic              req_valid;
	logic              wr_ctrl;
	logic              wr_cnt;
	logic [7:0]        wd;

	// Timing
	logic [PW-1:0] sys_pre;
	logic [4:0]    sub_pre;
	logic          tick;
	logic          run;
	logic          overflow;
	logic          ovf_pending;
	logic          ref_edge;
	logic          rst_active;
	logic [RW-1:0] rst_cnt;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sub_sync <= 2'h0;
			osc_sync <= 2'h0;
			sub_prev <= 1'b0;
			osc_prev <= 1'b0;
		end
		else
		begin
			sub_sync <= {sub_sync[0], sub_clk_i};
			osc_sync <= {osc_sync[0], osc_clk_i};
			sub_prev <= sub_sync[1];
			osc_prev <= osc_sync[1];
		end
	end

	assign sub_rise = sub_sync[1] & ~sub_prev;
	assign osc_rise = osc_sync[1] & ~osc_prev;

	// Pin synchroniser has no reset: the chip reset must never mask the pin,
	// the only asynchronous source that clears the flag. Pin need only be sampled low at one clock edge.
	always_ff @(posedge clk_sys_i)
	begin
		pin_sync <= {pin_sync[0], external_reset_pin_n_i};
	end

	// Address phase capture; zero wait states
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_valid <= 1'b0;
			req       <= '0;
		end
		else if (hready_i)
		begin
			req_valid <= hsel_i & htrans_i[1];
			req.write <= hwrite_i;
			req.addr  <= haddr_i[wdt_pkg::ADDR_W-1:0];
		end
	end

	assign wd      = hwdata_i[7:0];
	assign wr_ctrl = req_valid & req.write
		& (req.addr == {wdt_pkg::IDX_CTRL_STATUS, 2'b00});
	assign wr_cnt  = req_valid & req.write & counter_write_enable
		& (req.addr == {wdt_pkg::IDX_COUNTER, 2'b00});

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// Read data registered at the address phase; unmapped reads give zero
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h0000_0000;
		else if (hready_i & hsel_i & htrans_i[1] & ~hwrite_i)
		begin
			case (haddr_i[wdt_pkg::ADDR_W-1:2])
				wdt_pkg::IDX_CTRL_STATUS:
					hrdata_o <= {24'h000000, wdt_pkg::INHIBIT_MASK
						| {1'b0, counter_write_enable, 1'b0,
						control_write_unlock, 1'b0, watchdog_enable,
						1'b0, overflow_reset_flag}};
				wdt_pkg::IDX_COUNTER:
					hrdata_o <= {24'h000000, watchdog_counter};
				wdt_pkg::IDX_PORT_SEL_3:
					hrdata_o <= {24'h000000, port_function_select_3};
				wdt_pkg::IDX_CLOCK_STOP_2:
					hrdata_o <= {24'h000000, module_clock_stop_reg};
				wdt_pkg::IDX_POWER_MODE:
					hrdata_o <= {29'h00000000, power_mode};
				default:
					hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Counter-write enable and unlock, each gated by its inhibit bit
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			counter_write_enable <= 1'b0;
			control_write_unlock <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			if (!wd[wdt_pkg::BIT_CNT_WR_INH])
				counter_write_enable <= wd[wdt_pkg::BIT_CNT_WR_EN];
			if (!wd[wdt_pkg::BIT_UNLOCK_INH])
				control_write_unlock <= wd[wdt_pkg::BIT_UNLOCK];
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_enable <= 1'b0;
		else if (wr_ctrl & control_write_unlock
			& !wd[wdt_pkg::BIT_ENABLE_INH])
			watchdog_enable <= wd[wdt_pkg::BIT_ENABLE];
	end

	// Flag lives outside the chip reset so the overflow survives it;
	// only the pin clears it asynchronously.
	// flag set on overflow
	always_ff @(posedge clk_sys_i or negedge pin_sync[1])
	begin
		if (!pin_sync[1])
			overflow_reset_flag <= 1'b0;
		else if (ovf_pending)
			overflow_reset_flag <= 1'b1;
		else if (wr_ctrl & control_write_unlock
			& !wd[wdt_pkg::BIT_FLAG_INH] & !wd[wdt_pkg::BIT_FLAG])
			overflow_reset_flag <= 1'b0;
	end

	// Plain registers for source select, standby and power mode
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			port_function_select_3 <= wdt_pkg::RST_PORT_SEL_3;
			module_clock_stop_reg  <= wdt_pkg::RST_CLOCK_STOP_2;
			power_mode             <= wdt_pkg::WDT_ACTIVE;
		end
		else if (req_valid & req.write)
		begin
			if (req.addr == {wdt_pkg::IDX_CLOCK_STOP_2, 2'b00})
				module_clock_stop_reg <= {4'hF, wd[3:0]};
			if (req.addr == {wdt_pkg::IDX_PORT_SEL_3, 2'b00})
				port_function_select_3 <= wd;
			if (req.addr == {wdt_pkg::IDX_POWER_MODE, 2'b00})
				power_mode <= wdt_pkg::wdt_mode_t'(wd[2:0]);
		end
	end

	always_comb
	begin
		run = watchdog_enable;
		if (!watchdog_enable
			&& !module_clock_stop_reg[wdt_pkg::BIT_STANDBY_N])
			run = 1'b0;
		case (power_mode)
			wdt_pkg::WDT_ACTIVE,
			wdt_pkg::WDT_SLEEP:
				run = run;
			wdt_pkg::WDT_SUBACTIVE:
				run = run & port_function_select_3[wdt_pkg::BIT_CLK_SEL];
			default:
				run = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sys_pre <= '0;
			sub_pre <= 5'h00;
		end
		else
		begin
			sys_pre <= run ? sys_pre + 1'b1 : '0;
			if (!run)
				sub_pre <= 5'h00;
			else if (sub_rise)
				sub_pre <= sub_pre + 5'h01;
		end
	end

	assign tick = run & (port_function_select_3[wdt_pkg::BIT_CLK_SEL]
		? (sub_rise & (sub_pre == 5'(SUB_DIV - 1)))
		: (sys_pre == PW'(SYS_DIV - 1)));
	// A refresh write in the wrap cycle cancels the overflow
	assign overflow = tick & ~wr_cnt & (watchdog_counter == 8'hFF);
	assign ref_edge = port_function_select_3[wdt_pkg::BIT_CLK_SEL]
		? sub_rise : 1'b1;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_counter <= wdt_pkg::RST_COUNTER;
		else if (wr_cnt)
			watchdog_counter <= wd;
		else if (tick)
			watchdog_counter <= watchdog_counter + 8'h01;
	end

	// Reset pulse lives on the pin reset only, since it drives rst_i itself.
	// chip reset on wrap
	always_ff @(posedge clk_sys_i or negedge pin_sync[1])
	begin
		if (!pin_sync[1])
		begin
			ovf_pending      <= 1'b0;
			rst_active       <= 1'b0;
			rst_cnt          <= '0;
			internal_reset_o <= 1'b0;
		end
		else if (overflow && !rst_active)
			ovf_pending <= 1'b1;
		else if (ovf_pending && ref_edge)
		begin
			ovf_pending      <= 1'b0;
			rst_active       <= 1'b1;
			rst_cnt          <= '0;
			internal_reset_o <= 1'b1;
		end
		else if (rst_active && osc_rise)
		begin
			if (rst_cnt == RW'(RST_LEN - 1))
			begin
				rst_active       <= 1'b0;
				internal_reset_o <= 1'b0;
			end
			rst_cnt <= rst_cnt + 1'b1;
		end
	end

endmodule : wdt_core

//--- verification/wdt_core_assertions.sv
// Port checker for the watchdog core: bus answer, read-back, reset pulse.
// Assumes the bench runs the oscillator clock at six system clocks.
module wdt_chk
#(
	parameter int RST_LEN = 8
)
(
	// Clock and resets
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        external_reset_pin_n_i,
	// Bus and chip reset
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        internal_reset_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Slack of two oscillator periods below and one above covers edge phase and synchroniser
	localparam int OSC_CYC = 6;
	localparam int LO_LEN  = (RST_LEN - 2) * OSC_CYC;
	localparam int HI_LEN  = (RST_LEN + 1) * OSC_CYC;
	logic [15:0] hi_cnt;
	logic        rd;
	assign rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			hi_cnt <= 16'h0000;
		else if (internal_reset_o)
			hi_cnt <= hi_cnt + 16'h0001;
		else
			hi_cnt <= 16'h0000;
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	sequence s_rd_cs;
		rd && haddr_i[17:2] == wdt_pkg::IDX_CTRL_STATUS;
	endsequence
	sequence s_pin_low;
		!external_reset_pin_n_i [*3];
	endsequence
	a_ready_high: assert property (hreadyout_o)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp_o)
		else $error("hresp not okay");
	a_upper_zero: assert property (hrdata_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_inhibit_ones: assert property (s_rd_cs |=>
		(hrdata_o[7:0] & 8'hAA) == 8'hAA)
		else $error("inhibit bit read zero");
	a_rdata_hold: assert property (!rd |=> $stable(hrdata_o))
		else $error("read data moved");
	// A pin reset may legally cut the pulse short
	a_pulse_min: assert property ($fell(internal_reset_o)
		&& external_reset_pin_n_i |-> hi_cnt >= LO_LEN)
		else $error("reset pulse short");
	a_pulse_max: assert property (internal_reset_o |->
		hi_cnt < HI_LEN)
		else $error("reset pulse long");
	a_pin_clears: assert property (s_pin_low |=>
		!internal_reset_o)
		else $error("pin left reset high");
endmodule : wdt_chk

bind wdt_core wdt_chk #(.RST_LEN(RST_LEN)) chk_u
(
	.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.external_reset_pin_n_i(external_reset_pin_n_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.internal_reset_o(internal_reset_o)
);

//--- verification/tb_top.sv
// Bench for the watchdog: key bits, counting per mode, overflow reset.
// Assumes a zero-wait AHB-Lite slave; internal reset is not fed back.
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %s exp %0h got %0h", nm, e, g); \
		end \
	end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] A_CS  = {14'h0, wdt_pkg::IDX_CTRL_STATUS, 2'b00};
	localparam logic [31:0] A_CNT = {14'h0, wdt_pkg::IDX_COUNTER, 2'b00};
	localparam logic [31:0] A_PS3 = {14'h0, wdt_pkg::IDX_PORT_SEL_3, 2'b00};
	localparam logic [31:0] A_CK2 = {14'h0, wdt_pkg::IDX_CLOCK_STOP_2, 2'b00};
	localparam logic [31:0] A_PM  = {14'h0, wdt_pkg::IDX_POWER_MODE, 2'b00};
	logic        clk_sys_i;
	logic        rst_i;
	logic        pin_n;
	logic        sub_clk;
	logic        osc_clk;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        irst;
	int          n_mismatch;
	int          total_checks;
	wdt_core #(.SYS_DIV(16), .RST_LEN(8)) dut_u
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.external_reset_pin_n_i(pin_n), .sub_clk_i(sub_clk),
		.osc_clk_i(osc_clk), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(), .internal_reset_o(irst)
	);
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic wait_rdy();
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_sys_i);
			if (hready === 1'b1)
				return;
		end
		n_mismatch++;
		test_done();
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		wait_rdy();
		q = hrdata;
	endtask : xfer
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(string nm, logic [31:0] a, logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 8'h00, q);
		`CHK(nm, e, q)
	endtask : rd_chk
	// Counter advance over a fixed window must lie in lo..hi
	task automatic step_chk(string nm, logic [7:0] lo, logic [7:0] hi);
		logic [31:0] c0;
		logic [31:0] c1;
		logic [7:0]  d;
		xfer(1'b0, A_CNT, 8'h00, c0);
		repeat (300) @(posedge clk_sys_i);
		xfer(1'b0, A_CNT, 8'h00, c1);
		d = c1[7:0] - c0[7:0];
		`CHK(nm, 1'b1, d >= lo && d <= hi)
	endtask : step_chk
	task automatic wait_irst(input logic v);
		for (int i = 0; i < 200 && irst !== v; i++)
			@(posedge clk_sys_i);
		`CHK("irst", v, irst)
		if (irst !== v)
			test_done();
	endtask : wait_irst
	task automatic t_regs();
		rd_chk("cs rst", A_CS, 32'hAA);
		rd_chk("cnt rst", A_CNT, 32'h0);
		rd_chk("ck2 rst", A_CK2, 32'hFF);
		rd_chk("ps3 rst", A_PS3, 32'h0);
		rd_chk("unmapped", 32'h100, 32'h0);
	endtask : t_regs
	task automatic t_keys();
		wr(A_CNT, 8'h55);
		rd_chk("cnt locked", A_CNT, 32'h0);
		wr(A_CS, 8'h04);
		rd_chk("en locked", A_CS, 32'hAA);
		wr(A_CS, 8'h10);
		rd_chk("unlock", A_CS, 32'hBA);
		wr(A_CS, 8'hE0);
		rd_chk("inhibit", A_CS, 32'hBA);
		wr(A_CS, 8'h50);
		wr(A_CNT, 8'h37);
		rd_chk("cnt load", A_CNT, 32'h37);
		step_chk("cnt hold", 8'd0, 8'd0);
		wr(A_CS, 8'h54);
		rd_chk("enabled", A_CS, 32'hFE);
	endtask : t_keys
	task automatic t_modes();
		logic run;
		wr(A_CNT, 8'h00);
		for (int s = 0; s < 2; s++)
		begin
			wr(A_PS3, s[0] ? 8'h20 : 8'h00);
			for (int m = 0; m < 6; m++)
			begin
				wr(A_PM, m[7:0]);
				run = m < 2 || (s == 1 && m == 3);
				step_chk("mode", !run ? 8'd0 : s[0] ? 8'd2 : 8'd18,
					!run ? 8'd0 : s[0] ? 8'd3 : 8'd19);
			end
		end
		wr(A_PM, 8'h00);
		wr(A_PS3, 8'h00);
		wr(A_CK2, 8'hFB);
		rd_chk("ck2 kept", A_CK2, 32'hFB);
		step_chk("standby wait", 8'd18, 8'd19);
		wr(A_CS, 8'h50);
		step_chk("disabled", 8'd0, 8'd0);
		wr(A_CK2, 8'hFF);
	endtask : t_modes
	task automatic t_over();
		wr(A_CNT, 8'hFE);
		wr(A_CS, 8'h54);
		wait_irst(1'b1);
		wait_irst(1'b0);
		rd_chk("flag set", A_CS, 32'hFF);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd_chk("flag kept", A_CS, 32'hAB);
		wr(A_CS, 8'h12);
		rd_chk("flag guard", A_CS, 32'hBB);
		wr(A_CS, 8'h10);
		rd_chk("flag clear", A_CS, 32'hBA);
		wr(A_CS, 8'h54);
		wr(A_CNT, 8'hFF);
		wait_irst(1'b1);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		pin_n <= 1'b1;
		@(posedge clk_sys_i);
		`CHK("irst pin", 1'b0, irst)
		rd_chk("pin clear", A_CS, 32'hFE);
	endtask : t_over
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		sub_clk = 1'b0;
		forever #20 sub_clk = ~sub_clk;
	end
	initial
	begin
		osc_clk = 1'b0;
		forever #30 osc_clk = ~osc_clk;
	end
	initial
	begin
		rst_i = 1'b1;
		pin_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		pin_n <= 1'b1;
		@(posedge clk_sys_i);
		t_regs();
		t_keys();
		t_modes();
		t_over();
		test_done();
	end
endmodule : tb_top
